// >>> rtl/regfile_pkg.sv
package regfile_pkg;

   // ****************************************
   // operand sizes and widths
   // ****************************************
   typedef enum logic [1:0] {
      size_byte,
      size_word,
      size_long,
      size_none
   } size_type;

   localparam int DATA_W = 32;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int NUM_DATA = 8;
   localparam int NUM_ADDR = 7;
   localparam int REG_NUM_W = 3;
   localparam int BIT_NUM_W = 5;
   localparam logic [31:0] REG_RESET = 32'h00000000;

   // ****************************************
   // operation word fields
   // ****************************************
   localparam int EA_REG_LSB = 0;
   localparam int EA_MODE_LSB = 3;
   localparam int EA_FIELD_W = 3;
   localparam int OP_SIZE_LSB = 6;
   localparam int OP_GROUP_LSB = 12;
   localparam int OP_IMM_BIT = 8;
   localparam int MAX_WORDS = 5;
   localparam int LEN_W = 3;

   typedef enum logic [1:0] {
      kind_op,
      kind_imm,
      kind_ext
   } word_kind_type;

endpackage

// >>> rtl/operand_regfile.sv
`timescale 1ns/10ps
// How it works
// - byte 8, word 16, long 32 bits
// - size from opword field or operation
// - bus bytes always paired into words
// - eight data registers, 1/8/16/32 bit operands
// - data regs 32 bit, sizes low-aligned
// - bit 0 is lsb, bit 31 msb
// - data reg: only low portion touched
// - seven address regs plus stack pointers
// - byte size illegal on address regs
// - address source: low word or long
// - address destination written in full
// - word ops to address: sign extend
// - instructions one to five words long
// - instructions start on even address
// - length decoded from operation word alone
// - later words: immediate or ea extension
// - ea is 3-bit mode plus register
module operand_regfile
   import regfile_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic supervisor,
   input wire logic rd_a_is_addr,
   input wire logic [REG_NUM_W-1:0] rd_a_num,
   input wire size_type rd_a_size,
   input wire logic rd_a_sext,
   input wire logic [BIT_NUM_W-1:0] rd_a_bit_num,
   output logic [DATA_W-1:0] rd_a_data,
   output logic rd_a_bit,
   output logic rd_a_illegal,
   input wire logic rd_b_is_addr,
   input wire logic [REG_NUM_W-1:0] rd_b_num,
   input wire size_type rd_b_size,
   input wire logic rd_b_sext,
   output logic [DATA_W-1:0] rd_b_data,
   output logic rd_b_illegal,
   input wire logic wr_en,
   input wire logic wr_is_addr,
   input wire logic [REG_NUM_W-1:0] wr_num,
   input wire size_type wr_size,
   input wire logic [DATA_W-1:0] wr_data,
   output logic wr_reject,
   input wire logic fetch_start,
   input wire logic [ADDR_W-1:0] fetch_pc,
   input wire logic bus_byte_valid,
   input wire logic [BYTE_W-1:0] bus_byte,
   output logic fetch_busy,
   output logic align_fault,
   output logic word_valid,
   output logic [WORD_W-1:0] word_data,
   output word_kind_type word_kind,
   output logic [LEN_W-1:0] word_index,
   output logic [LEN_W-1:0] inst_len,
   output size_type inst_size,
   output logic [EA_FIELD_W-1:0] ea_mode,
   output logic [EA_FIELD_W-1:0] ea_reg,
   output logic inst_done
);

   // ****************************************
   // storage
   // ****************************************
   logic [DATA_W-1:0] data_q [NUM_DATA];
   logic [DATA_W-1:0] addr_q [NUM_ADDR];
   logic [DATA_W-1:0] usp_q;
   logic [DATA_W-1:0] ssp_q;

   // ****************************************
   // helpers
   // ****************************************
   // raw 32-bit address register, a7 picks the active stack pointer
   function automatic logic [DATA_W-1:0] addr_raw(input logic [REG_NUM_W-1:0] n,
                                                  input logic sup);
      logic [DATA_W-1:0] v;
      v = REG_RESET;
      if (n == 3'h7) begin
         v = sup ? ssp_q : usp_q;
      end else begin
         v = addr_q[n];
      end
      return v;
   endfunction

   // size view of a source register; upper bits masked for byte and unsigned word, sign-filled for signed word, size_none passes all 32
   function automatic logic [DATA_W-1:0] size_view(input logic [DATA_W-1:0] r,
                                                   input size_type s,
                                                   input logic sext);
      logic [DATA_W-1:0] v;
      v = r;
      case (s)
         size_byte: v = {24'h000000, r[7:0]};
         size_word: v = sext ? {{16{r[15]}}, r[15:0]}
                             : {16'h0000, r[15:0]};
         size_long: v = r;
         default: v = r;
      endcase
      return v;
   endfunction

   // one read port: data or address register, sized
   function automatic logic [DATA_W-1:0] read_port(input logic is_addr,
                                                   input logic [REG_NUM_W-1:0] n,
                                                   input size_type s,
                                                   input logic sext,
                                                   input logic sup);
      logic [DATA_W-1:0] r;
      r = is_addr ? addr_raw(n, sup) : data_q[n];
      return size_view(r, s, sext);
   endfunction

   // ****************************************
   // read ports
   // ****************************************
   // registered reads; a same-cycle write is not visible yet
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_a_data <= REG_RESET;
         rd_b_data <= REG_RESET;
         rd_a_bit <= 1'b0;
      end else begin
         rd_a_data <= read_port(rd_a_is_addr, rd_a_num, rd_a_size,
                                rd_a_sext, supervisor);
         rd_b_data <= read_port(rd_b_is_addr, rd_b_num, rd_b_size,
                                rd_b_sext, supervisor);
         rd_a_bit <= data_q[rd_a_num][rd_a_bit_num];
      end
   end

   // byte reads of address registers are flagged; the low byte is still loaded into the read data
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_a_illegal <= 1'b0;
         rd_b_illegal <= 1'b0;
      end else begin
         rd_a_illegal <= rd_a_is_addr && (rd_a_size == size_byte);
         rd_b_illegal <= rd_b_is_addr && (rd_b_size == size_byte);
      end
   end

   // ****************************************
   // write port
   // ****************************************
   logic wr_addr_ok;
   logic [DATA_W-1:0] wr_addr_val;
   logic [DATA_W-1:0] wr_mask;

   // address destination: full 32 bits, word data sign extended
   always_comb begin
      wr_addr_ok = (wr_size == size_word) || (wr_size == size_long);
      wr_addr_val = size_view(wr_data, wr_size, 1'b1);
      case (wr_size)
         size_byte: wr_mask = 32'h000000FF;
         size_word: wr_mask = 32'h0000FFFF;
         size_long: wr_mask = 32'hFFFFFFFF;
         default: wr_mask = 32'h00000000;
      endcase
   end

   // data registers merge only the sized low portion
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_DATA; i++) begin
            data_q[i] <= REG_RESET;
         end
      end else if (wr_en && !wr_is_addr) begin
         data_q[wr_num] <= (data_q[wr_num] & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   // address registers and both stack pointers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_ADDR; i++) begin
            addr_q[i] <= REG_RESET;
         end
         usp_q <= REG_RESET;
         ssp_q <= REG_RESET;
      end else if (wr_en && wr_is_addr && wr_addr_ok) begin
         if (wr_num == 3'h7) begin
            if (supervisor) begin
               ssp_q <= wr_addr_val;
            end else begin
               usp_q <= wr_addr_val;
            end
         end else begin
            addr_q[wr_num] <= wr_addr_val;
         end
      end
   end

   // rejected byte writes to address registers leave them untouched
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reject <= 1'b0;
      end else begin
         wr_reject <= wr_en && wr_is_addr && !wr_addr_ok;
      end
   end

   // ****************************************
   // operation word decode
   // ****************************************
   // extension words demanded by the effective address, and by the size for mode 7 register 4
   function automatic logic [LEN_W-1:0] ea_words(input logic [2:0] m,
                                                 input logic [2:0] r,
                                                 input size_type s);
      logic [LEN_W-1:0] n;
      n = 3'h0;
      case (m)
         3'h5, 3'h6: n = 3'h1;
         3'h7: begin
            case (r)
               3'h0, 3'h2, 3'h3: n = 3'h1;
               3'h1: n = 3'h2;
               3'h4: n = (s == size_long) ? 3'h2 : 3'h1;
               default: n = 3'h0;
            endcase
         end
         default: n = 3'h0;
      endcase
      return n;
   endfunction

   // size field: 2'b11 is not a size; treated as word
   function automatic size_type op_size(input logic [WORD_W-1:0] w);
      logic [1:0] f;
      f = w[OP_SIZE_LSB +: 2];
      return (f == 2'b11) ? size_word : size_type'(f);
   endfunction

   // immediate group carries its own data words ahead of ea words
   function automatic logic [LEN_W-1:0] imm_words(input logic [WORD_W-1:0] w);
      logic is_imm;
      is_imm = (w[OP_GROUP_LSB +: 4] == 4'h0) && !w[OP_IMM_BIT];
      if (!is_imm) begin
         return 3'h0;
      end
      return (op_size(w) == size_long) ? 3'h2 : 3'h1;
   endfunction

   // ****************************************
   // instruction framing
   // ****************************************
   typedef enum logic [1:0] {
      fr_idle,
      fr_high,
      fr_low
   } frame_state_type;

   frame_state_type frame_q;
   logic [BYTE_W-1:0] high_q;
   logic [LEN_W-1:0] cnt_q;
   logic [LEN_W-1:0] imm_left_q;
   logic [WORD_W-1:0] new_word;
   logic [LEN_W-1:0] op_len;
   logic [LEN_W-1:0] op_imm;
   logic [LEN_W-1:0] len_now;
   logic word_fire;

   assign new_word = {high_q, bus_byte}; // high byte at even address
   assign word_fire = (frame_q == fr_low) && bus_byte_valid;
   assign op_imm = imm_words(new_word);
   assign op_len = 3'h1 + op_imm + ea_words(new_word[EA_MODE_LSB +: 3],
                                            new_word[EA_REG_LSB +: 3],
                                            op_size(new_word));
   assign len_now = (cnt_q == 3'h0) ? op_len : inst_len;
   assign fetch_busy = (frame_q != fr_idle);

   // frame sequencer; bytes only ever taken as complete pairs
   always_ff @(posedge clk) begin
      if (rst) begin
         frame_q <= fr_idle;
         high_q <= 8'h00;
         cnt_q <= 3'h0;
      end else begin
         case (frame_q)
            fr_idle: begin
               if (fetch_start && !fetch_pc[0]) begin
                  frame_q <= fr_high;
                  cnt_q <= 3'h0;
               end
            end
            fr_high: begin
               if (bus_byte_valid) begin
                  high_q <= bus_byte;
                  frame_q <= fr_low;
               end
            end
            fr_low: begin
               if (bus_byte_valid) begin
                  cnt_q <= cnt_q + 3'h1;
                  frame_q <= (cnt_q + 3'h1 >= len_now) ? fr_idle : fr_high;
               end
            end
            default: frame_q <= fr_idle;
         endcase
      end
   end

   // length, size and ea fields latched from the operation word
   always_ff @(posedge clk) begin
      if (rst) begin
         inst_len <= 3'h0;
         inst_size <= size_word;
         ea_mode <= 3'h0;
         ea_reg <= 3'h0;
         imm_left_q <= 3'h0;
      end else if (word_fire && cnt_q == 3'h0) begin
         inst_len <= op_len;
         inst_size <= op_size(new_word);
         ea_mode <= new_word[EA_MODE_LSB +: 3];
         ea_reg <= new_word[EA_REG_LSB +: 3];
         imm_left_q <= op_imm;
      end else if (word_fire && imm_left_q != 3'h0) begin
         imm_left_q <= imm_left_q - 3'h1;
      end
   end

   // word outputs, tagged by role within the instruction
   always_ff @(posedge clk) begin
      if (rst) begin
         word_valid <= 1'b0;
         word_data <= 16'h0000;
         word_kind <= kind_op;
         word_index <= 3'h0;
         inst_done <= 1'b0;
      end else begin
         word_valid <= word_fire;
         inst_done <= word_fire && (cnt_q + 3'h1 >= len_now);
         if (word_fire) begin
            word_data <= new_word;
            word_index <= cnt_q;
            if (cnt_q == 3'h0) begin
               word_kind <= kind_op;
            end else if (imm_left_q != 3'h0) begin
               word_kind <= kind_imm;
            end else begin
               word_kind <= kind_ext;
            end
         end
      end
   end

   // odd start address refused; nothing is fetched for it
   always_ff @(posedge clk) begin
      if (rst) begin
         align_fault <= 1'b0;
      end else begin
         align_fault <= (frame_q == fr_idle) && fetch_start && fetch_pc[0];
      end
   end

endmodule

// >>> test/operand_regfile_asserts.sv
`timescale 1ns/10ps
// ****************************************
// operand register file port checks
// ****************************************
module operand_regfile_checker
   import regfile_pkg::*;
#(
   parameter int ADDR_W = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rd_a_is_addr,
   input wire size_type rd_a_size,
   input wire logic rd_a_sext,
   input wire logic [DATA_W-1:0] rd_a_data,
   input wire logic rd_a_illegal,
   input wire logic wr_en,
   input wire logic wr_is_addr,
   input wire size_type wr_size,
   input wire logic wr_reject,
   input wire logic fetch_start,
   input wire logic [ADDR_W-1:0] fetch_pc,
   input wire logic fetch_busy,
   input wire logic align_fault,
   input wire logic bus_byte_valid,
   input wire logic word_valid,
   input wire word_kind_type word_kind,
   input wire logic [LEN_W-1:0] word_index,
   input wire logic [LEN_W-1:0] inst_len,
   input wire logic inst_done
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // requests that must be refused
   sequence s_addr_byte_wr;
      wr_en && wr_is_addr && wr_size == size_byte;
   endsequence
   sequence s_odd_start;
      fetch_start && !fetch_busy && fetch_pc[0];
   endsequence
   property p_wr_refuse;
      s_addr_byte_wr |=> wr_reject;
   endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("byte address write kept");
   property p_rd_illegal;
      rd_a_is_addr && rd_a_size == size_byte |=> rd_a_illegal;
   endproperty
   a_rd_illegal: assert property (p_rd_illegal) else $error("byte address read allowed");
   property p_byte_low;
      !rd_a_is_addr && rd_a_size == size_byte && !rd_a_sext |=> rd_a_data[31:8] == 24'h0;
   endproperty
   a_byte_low: assert property (p_byte_low) else $error("byte read not low aligned");
   property p_word_zero;
      rd_a_size == size_word && !rd_a_sext |=> rd_a_data[31:16] == 16'h0;
   endproperty
   a_word_zero: assert property (p_word_zero) else $error("word read upper half set");
   property p_word_sext;
      rd_a_size == size_word && rd_a_sext |=> rd_a_data[31:16] == {16{rd_a_data[15]}};
   endproperty
   a_word_sext: assert property (p_word_sext) else $error("word read not sign extended");
   property p_odd_pc;
      s_odd_start |=> align_fault && !fetch_busy;
   endproperty
   a_odd_pc: assert property (p_odd_pc) else $error("odd start not faulted");
   property p_word_pair;
      word_valid |-> $past(bus_byte_valid);
   endproperty
   a_word_pair: assert property (p_word_pair) else $error("word without second byte");
   property p_done_last;
      inst_done |-> word_valid && word_index == inst_len - 3'h1;
   endproperty
   a_done_last: assert property (p_done_last) else $error("done not on last word");
   property p_op_first;
      word_valid && word_index == 3'h0 |-> word_kind == kind_op;
   endproperty
   a_op_first: assert property (p_op_first) else $error("first word not operation");
endmodule
bind operand_regfile operand_regfile_checker #(.ADDR_W(ADDR_W)) i_operand_regfile_checker (
   .clk, .rst, .rd_a_is_addr, .rd_a_size, .rd_a_sext, .rd_a_data, .rd_a_illegal, .wr_en,
   .wr_is_addr, .wr_size, .wr_reject, .fetch_start, .fetch_pc, .fetch_busy, .align_fault,
   .bus_byte_valid, .word_valid, .word_kind, .word_index, .inst_len, .inst_done);

// >>> test/program_byte_source.sv
`timescale 1ns/10ps
// ****************************************
// program memory on the byte-wide bus
// ****************************************
module program_byte_source (
   input wire logic clk,
   input wire logic go,
   input wire logic slow,
   input wire logic [3:0] nbytes,
   input wire logic [79:0] prog,
   output logic bus_byte_valid,
   output logic [7:0] bus_byte
);
   int pos = 0;
   int left = 0;
   logic gap = 1'b0;
   // restart the byte stream when the fetch is started
   always @(posedge clk) begin
      if (go) begin
         pos = 0;
         left = int'(nbytes);
      end
   end
   // one byte per cycle, or every other cycle when slow
   always @(negedge clk) begin
      if (left > 0 && !(slow && gap)) begin
         bus_byte_valid <= 1'b1;
         bus_byte <= prog[79-8*pos -: 8]; // even byte first, pairs whole
         pos++;
         left--;
      end else begin
         bus_byte_valid <= 1'b0;
         bus_byte <= ~bus_byte; // idle lines never keep the last value
      end
      gap = slow ? ~gap : 1'b0;
   end
   initial begin
      bus_byte_valid = 1'b0;
      bus_byte = 8'h5A;
   end
endmodule

// >>> test/tb.sv
`timescale 1ns/10ps
// ****************************************
// operand register file bench
// ****************************************
module tb;
   import regfile_pkg::*;
   localparam int AW = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic supervisor = 1'b0;
   logic rd_a_is_addr = 1'b0, rd_a_sext = 1'b0, rd_b_is_addr = 1'b0, rd_b_sext = 1'b0;
   logic [2:0] rd_a_num = 3'h0, rd_b_num = 3'h0, wr_num = 3'h0;
   logic [4:0] rd_a_bit_num = 5'h00;
   size_type rd_a_size = size_long, rd_b_size = size_long, wr_size = size_long, s;
   logic wr_en = 1'b0, wr_is_addr = 1'b0, fetch_start = 1'b0, go = 1'b0, slow = 1'b0;
   logic [31:0] wr_data = 32'h0, rd_a_data, rd_b_data;
   logic [AW-1:0] fetch_pc = '0;
   logic [79:0] prog = '0;
   logic [3:0] nbytes = 4'h0;
   logic bus_byte_valid, rd_a_bit, rd_a_illegal, rd_b_illegal, wr_reject, fetch_busy;
   logic align_fault, word_valid, inst_done;
   logic [7:0] bus_byte;
   logic [15:0] word_data;
   word_kind_type word_kind;
   logic [2:0] word_index, inst_len, ea_mode, ea_reg;
   size_type inst_size;
   logic [31:0] dm [8];
   logic [31:0] am [9];
   logic [15:0] ops [6] = '{16'h303C, 16'h4200, 16'h0000, 16'h0080, 16'h00B9, 16'h0128};
   int bad_count = 0;
   int comparisons = 0;
   operand_regfile #(.ADDR_W(AW)) i_operand_regfile (.clk, .rst, .supervisor, .rd_a_is_addr,
      .rd_a_num, .rd_a_size, .rd_a_sext, .rd_a_bit_num, .rd_a_data, .rd_a_bit, .rd_a_illegal,
      .rd_b_is_addr, .rd_b_num, .rd_b_size, .rd_b_sext, .rd_b_data, .rd_b_illegal, .wr_en,
      .wr_is_addr, .wr_num, .wr_size, .wr_data, .wr_reject, .fetch_start, .fetch_pc,
      .bus_byte_valid, .bus_byte, .fetch_busy, .align_fault, .word_valid, .word_data,
      .word_kind, .word_index, .inst_len, .inst_size, .ea_mode, .ea_reg, .inst_done);
   program_byte_source i_program_byte_source (.clk, .go, .slow, .nbytes, .prog,
      .bus_byte_valid, .bus_byte);
   always #2.5 clk = ~clk;
   // compare and count
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // expected values: a7 follows the privilege level
   function automatic int ai(logic [2:0] n);
      return (n == 3'h7) ? 7 + int'(supervisor) : int'(n);
   endfunction
   function automatic logic [31:0] sized(logic [31:0] v, size_type z, logic sx);
      if (z == size_byte) return {24'h0, v[7:0]};
      if (z == size_word) return sx ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]};
      return v;
   endfunction
   function automatic int imm_of(logic [15:0] op);
      if (op[15:12] != 4'h0 || op[8]) return 0;
      return (op[7:6] == 2'b10) ? 2 : 1;
   endfunction
   function automatic int ea_of(logic [15:0] op);
      if (op[5:3] == 3'h5 || op[5:3] == 3'h6) return 1;
      if (op[5:3] != 3'h7 || op[2:0] > 3'h4) return 0;
      return (op[2:0] == 3'h1 || (op[2:0] == 3'h4 && op[7:6] == 2'b10)) ? 2 : 1;
   endfunction
   // one write cycle, then update the model
   task automatic wr(logic isa, logic [2:0] n, size_type z, logic [31:0] v);
      @(negedge clk);
      {wr_en, wr_is_addr, wr_num, wr_data} = {1'b1, isa, n, v};
      wr_size = z;
      @(negedge clk);
      wr_en = 1'b0;
      check(32'(wr_reject), 32'(isa && (z == size_byte || z == size_none)));
      if (!isa && z == size_byte) dm[n][7:0] = v[7:0];
      if (!isa && z == size_word) dm[n][15:0] = v[15:0];
      if (!isa && z == size_long) dm[n] = v;
      if (isa && z == size_word) am[ai(n)] = {{16{v[15]}}, v[15:0]};
      if (isa && z == size_long) am[ai(n)] = v;
   endtask
   // both ports read the same size, port b from the next register
   task automatic rd(logic isa, logic [2:0] n, size_type z, logic sx);
      logic [4:0] b;
      logic [31:0] va;
      logic [31:0] vb;
      logic bad;
      b = 5'($urandom);
      bad = isa && z == size_byte;
      va = isa ? am[ai(n)] : dm[n];
      vb = isa ? am[ai(n + 3'h1)] : dm[n + 3'h1];
      @(negedge clk);
      {rd_a_is_addr, rd_a_num, rd_a_sext, rd_a_bit_num} = {isa, n, sx, b};
      rd_a_size = z;
      {rd_b_is_addr, rd_b_num, rd_b_sext} = {isa, n + 3'h1, sx};
      rd_b_size = z;
      @(negedge clk);
      check(32'(rd_a_illegal), 32'(bad));
      check(32'(rd_b_illegal), 32'(bad));
      if (!bad) check(rd_a_data, sized(va, z, sx));
      if (!bad) check(rd_b_data, sized(vb, z, sx));
      if (!isa) check(32'(rd_a_bit), 32'(va[b]));
   endtask
   // frame one instruction from the byte stream
   task automatic fetch_one(logic [79:0] p, logic sl);
      int imm;
      int len;
      int i;
      int t;
      imm = imm_of(p[79:64]);
      len = 1 + imm + ea_of(p[79:64]);
      i = 0;
      t = 0;
      @(negedge clk);
      {fetch_start, go, prog, nbytes, slow} = {1'b1, 1'b1, p, 4'(2 * len), sl};
      fetch_pc = AW'($urandom) << 1;
      @(negedge clk);
      {fetch_start, go} = 2'b00;
      while (i < len && t < 40) begin
         if (word_valid === 1'b1) begin
            check(32'(word_index), i);
            check(32'(word_data), 32'(p[79-16*i -: 16]));
            check(32'(word_kind), 32'(i == 0 ? 0 : (i <= imm ? 1 : 2)));
            check(32'(inst_done), 32'(i == len - 1));
            if (i == 0) check({26'h0, ea_mode, ea_reg}, 32'(p[69:64]));
            if (i == 0) check(32'(inst_len), len);
            if (i == 0) check(32'(inst_size), (p[71:70] == 2'b11) ? 32'(size_word) : 32'(p[71:70]));
            i++;
         end
         t++;
         @(negedge clk);
      end
      check(i, len);
      check(32'(fetch_busy), 0);
   endtask
   // hang guard, far beyond the expected run
   initial begin
      #50000;
      bad_count++;
      give_verdict();
   end
   // main sequence
   initial begin
      void'($urandom(32'h6A4AA5D4));
      foreach (dm[i]) dm[i] = REG_RESET;
      foreach (am[i]) am[i] = REG_RESET;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      rd(1'b0, 3'h5, size_long, 1'b0);
      wr(1'b0, 3'h2, size_long, 32'h12345678);
      wr(1'b0, 3'h2, size_byte, 32'hFFFFFF9A);
      rd(1'b0, 3'h2, size_long, 1'b0);
      wr(1'b1, 3'h3, size_word, 32'h00008001);
      wr(1'b1, 3'h3, size_byte, 32'h000000FF);
      rd(1'b1, 3'h3, size_word, 1'b1);
      rd(1'b1, 3'h3, size_byte, 1'b0);
      repeat (80) begin
         supervisor = 1'($urandom);
         s = size_type'($urandom_range(3));
         wr(1'($urandom), 3'($urandom), s, $urandom);
         s = size_type'($urandom_range(3));
         rd(1'($urandom), 3'($urandom), s, s == size_word ? 1'($urandom) : 1'b0);
      end
      foreach (ops[k]) fetch_one({ops[k], 64'h123456789ABCDEF0}, 1'(k));
      @(negedge clk);
      {fetch_start, fetch_pc} = {1'b1, AW'(5)};
      @(negedge clk);
      fetch_start = 1'b0;
      check(32'(align_fault), 1);
      repeat (20) fetch_one(80'({$urandom, $urandom, $urandom}), 1'($urandom));
      give_verdict();
   end
endmodule
